// File: hw/server_pwm_edge_updater.v
// Contract
// RL1 - toggle mode: read pointed word, add first or second constant by toggle bit, write back
// RL2 - toggle mode: toggle bit inverts at end of each cycle; reads show present value
// RL3 - remap mode: always add first constant to pointed word and write back
// RL4 - remap mode: unused toggle bit still inverts each cycle; reads show it
// RL5 - control byte 43H means pwm mode 010, toggle operation, toggle bit starts one
// RL6 - control byte 40H means pwm mode 010 with toggle select clear: remap
// RL7 - toggle bit field written into control byte sets its starting value
// RL8 - no cycle count used; every interrupt is serviced with no hardware end
// RL9 - software stops pwm by clearing select bit, then reconfigures compare channel
// RL10 - any interrupt source may trigger either pwm mode
// RL11 - software disables interrupts and server while building the control block
// RL12 - remap uses two blocks differing only in pointer, low bytes 82H and 86H
// RL13 - toggle example: first constant on-time, second off-time; first cycle adds off-time
// RL14 - duty change in toggle mode via one normal interrupt reloading constants
// RL15 - remap on-time lengthened via one normal interrupt adding period plus extra
// RL16 - remap startup preloads timer with FFFFH so 0000H matches first
// RL17 - toggle bit has no coupling to the pin level
// RL18 - mode code in control bits 7 to 5; bits 4 to 0 depend on mode
// RL19 - service active only while the source select bit is set
// RL20 - addition is 16 bits wide, wrapping modulo 65536
// RL21 - constant choice uses toggle bit sampled at cycle start, before inversion
`timescale 1ns/1ps
`default_nettype none
`include "server_pwm_regs.vh"

module server_pwm_edge_updater (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire service_trigger,
    output reg mem_req,
    output reg mem_we,
    output reg [15:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire mem_ack,
    output reg busy,
    output reg alternate_select_out
);

    reg select_reg;
    reg [2:0] mode_reg;
    reg [2:0] spare_reg;
    reg toggle_mode_select_reg;
    reg alternate_select_bit_reg;
    reg [15:0] target_word_pointer_reg;
    reg [15:0] first_add_constant_reg;
    reg [15:0] second_add_constant_reg;
    reg pending_reg;
    reg use_second_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    wire [15:0] sum_word;
    wire [9:0] reg_index;
    wire access;
    wire wr_take;
    wire pwm_selected;
    wire start_cycle;
    wire cycle_done;
    wire control_write;
    wire select_write;
    wire pointer_write;
    wire const1_write;
    wire const2_write;
    wire read_done;
    reg [31:0] read_value;
    reg read_hit;

    // merge byte lanes of a 16-bit register
    function [15:0] lane16;
        input [15:0] old_value;
        input [31:0] new_value;
        input [3:0] strb;
        begin
            lane16[7:0] = strb[0] ? new_value[7:0] : old_value[7:0];
            lane16[15:8] = strb[1] ? new_value[15:8] : old_value[15:8];
        end
    endfunction

    // true when the bus hits a given register index
    function hit;
        input [9:0] index;
        input [9:0] target;
        begin
            hit = (index == target);
        end
    endfunction

    assign reg_index = paddr[11:2];
    assign access = psel & penable;
    assign wr_take = access & pready & pwrite;
    assign control_write = wr_take & hit(reg_index, `IDX_CONTROL) & pstrb[0];
    // per-register write strobes
    assign select_write = wr_take & hit(reg_index, `IDX_ENABLE) & pstrb[0];
    assign pointer_write = wr_take & hit(reg_index, `IDX_POINTER);
    assign const1_write = wr_take & hit(reg_index, `IDX_CONST1);
    assign const2_write = wr_take & hit(reg_index, `IDX_CONST2);
    assign pwm_selected = (mode_reg == `MODE_PWM); // RL18
    // no count check: any selected trigger is served
    assign start_cycle = state_reg[0] & pending_reg & select_reg & pwm_selected; // RL8 RL19
    assign cycle_done = state_reg[2] & mem_ack;
    // read acknowledge moves the cycle to its write phase
    assign read_done = state_reg[1] & mem_ack;

    pwm_sum_unit sum_unit (
        .word_in(mem_rdata),
        .first_const(first_add_constant_reg),
        .second_const(second_add_constant_reg),
        .use_second(use_second_reg),
        .sum_out(sum_word)
    );

    // apb answer: pready one cycle into the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RST_DATA;
        end else begin
            pready <= access & ~pready;
            if (access & ~pready) begin
                pslverr <= ~read_hit;
                prdata <= pwrite ? `RST_DATA : read_value;
            end else begin
                pslverr <= 1'b0;
                prdata <= `RST_DATA;
            end
        end
    end

    // read mux, unmapped indices answer with an error
    always @* begin
        read_value = `RST_DATA;
        read_hit = 1'b1;
        case (reg_index)
            `IDX_ENABLE: begin
                read_value[0] = select_reg;
            end
            `IDX_CONTROL: begin
                read_value[`MODE_HI:`MODE_LO] = mode_reg;
                read_value[`SPARE_HI:`SPARE_LO] = spare_reg;
                read_value[`TOGGLE_MODE_BIT] = toggle_mode_select_reg;
                read_value[`ALT_SELECT_BIT] = alternate_select_bit_reg; // RL2 RL4
            end
            `IDX_POINTER: begin
                read_value[15:0] = target_word_pointer_reg;
            end
            `IDX_CONST1: begin
                read_value[15:0] = first_add_constant_reg;
            end
            `IDX_CONST2: begin
                read_value[15:0] = second_add_constant_reg;
            end
            `IDX_STATUS: begin
                read_value[`STAT_BUSY] = ~state_reg[0];
                read_value[`STAT_PEND] = pending_reg;
                read_value[`STAT_ALTERNATE_SELECT_BIT] = alternate_select_bit_reg;
            end
            default: begin
                read_hit = 1'b0;
            end
        endcase
    end

    // server select bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= 1'b0;
        end else if (select_write) begin
            select_reg <= pwdata[0]; // RL19
        end
    end

    // control byte fields; 43H gives toggle operation, 40H gives remap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `RST_FIELD3;
            spare_reg <= `RST_FIELD3;
            toggle_mode_select_reg <= 1'b0;
        end else if (control_write) begin
            mode_reg <= pwdata[`MODE_HI:`MODE_LO]; // RL5 RL6 RL18
            spare_reg <= pwdata[`SPARE_HI:`SPARE_LO];
            toggle_mode_select_reg <= pwdata[`TOGGLE_MODE_BIT]; // RL5 RL6
        end
    end

    // pointer word, byte lanes merged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_word_pointer_reg <= `RST_WORD;
        end else if (pointer_write) begin
            target_word_pointer_reg <= lane16(target_word_pointer_reg, pwdata, pstrb);
        end
    end

    // first constant
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_add_constant_reg <= `RST_WORD;
        end else if (const1_write) begin
            first_add_constant_reg <= lane16(first_add_constant_reg, pwdata, pstrb);
        end
    end

    // second constant
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_add_constant_reg <= `RST_WORD;
        end else if (const2_write) begin
            second_add_constant_reg <= lane16(second_add_constant_reg, pwdata, pstrb);
        end
    end

    // toggle bit: software write seeds it, hardware inverts at cycle end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alternate_select_bit_reg <= 1'b0;
        end else if (control_write) begin
            // a seed written in the cycle-end edge wins over the inversion
            alternate_select_bit_reg <= pwdata[`ALT_SELECT_BIT]; // RL7
        end else if (cycle_done) begin
            // inverts in both modes
            alternate_select_bit_reg <= ~alternate_select_bit_reg; // RL2 RL4
        end
    end

    // trigger from any source; a new event beats the clear at cycle start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 1'b0;
        end else if (service_trigger & select_reg & pwm_selected) begin
            pending_reg <= 1'b1; // RL10
        end else if (start_cycle | ~select_reg) begin
            pending_reg <= 1'b0; // RL19
        end
    end

    // constant choice frozen at cycle start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_second_reg <= 1'b0;
        end else if (start_cycle) begin
            // remap ignores the toggle bit
            use_second_reg <= toggle_mode_select_reg & alternate_select_bit_reg; // RL1 RL3 RL21
        end
    end

    // next state of the word-bus cycle
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ST_IDLE: begin
                if (start_cycle) begin
                    state_next = `ST_READ;
                end
            end
            `ST_READ: begin
                if (mem_ack) begin
                    state_next = `ST_WRITE;
                end
            end
            `ST_WRITE: begin
                if (mem_ack) begin
                    state_next = `ST_IDLE;
                end
            end
            default: begin
                state_next = `ST_IDLE;
            end
        endcase
    end

    // one uninterruptible read-add-write cycle on the word bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= `ST_IDLE;
            busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy <= ~state_next[0];
        end
    end

    // request stays up through both phases
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= 1'b0;
        end else if (start_cycle) begin
            mem_req <= 1'b1; // RL1 RL3
        end else if (cycle_done) begin
            mem_req <= 1'b0;
        end
    end

    // write phase follows the read acknowledge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we <= 1'b0;
        end else if (read_done) begin
            mem_we <= 1'b1;
        end else if (start_cycle | cycle_done) begin
            mem_we <= 1'b0;
        end
    end

    // pointer latched once per cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr <= `RST_WORD;
        end else if (start_cycle) begin
            mem_addr <= target_word_pointer_reg; // RL1 RL3
        end
    end

    // sum taken at the read acknowledge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wdata <= `RST_WORD;
        end else if (read_done) begin
            mem_wdata <= sum_word; // RL1 RL3 RL20
        end
    end

    // status copy only; pin level is owned by the port logic
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alternate_select_out <= 1'b0;
        end else begin
            alternate_select_out <= alternate_select_bit_reg; // RL17
        end
    end

endmodule // server_pwm_edge_updater

`default_nettype wire

// File: common/server_pwm_regs.vh
`ifndef SERVER_PWM_REGS_VH
`define SERVER_PWM_REGS_VH

// register indices, byte address is four times the index
`define IDX_SELECT 10'h000
`define IDX_CONTROL 10'h001
`define IDX_ENABLE 10'h000
`define IDX_POINTER 10'h002
`define IDX_CONST1 10'h003
`define IDX_CONST2 10'h004
`define IDX_STATUS 10'h005

// control byte fields
`define MODE_HI 7
`define MODE_LO 5
`define TOGGLE_MODE_BIT 1
`define ALT_SELECT_BIT 0
`define SPARE_HI 4
`define SPARE_LO 2
`define MODE_PWM 3'h2

// status fields
`define STAT_BUSY 0
`define STAT_PEND 1
`define STAT_ALTERNATE_SELECT_BIT 2

// reset values
`define RST_CONTROL 8'h00
`define RST_FIELD3 3'h0
`define RST_WORD 16'h0000
`define RST_DATA 32'h0000_0000

// fsm states, one-hot
`define ST_IDLE 3'h1
`define ST_READ 3'h2
`define ST_WRITE 3'h4

`endif

// File: hw/pwm_sum_unit.v
`timescale 1ns/1ps
`default_nettype none

module pwm_sum_unit (
    input wire [15:0] word_in,
    input wire [15:0] first_const,
    input wire [15:0] second_const,
    input wire use_second,
    output wire [15:0] sum_out
);

    wire [15:0] addend;

    // second constant only when the latched toggle choice says so
    assign addend = use_second ? second_const : first_const; // RL1
    // 16-bit wrap, carry dropped like a free-running timer
    assign sum_out = word_in + addend; // RL20

endmodule // pwm_sum_unit

`default_nettype wire

// File: bench/server_pwm_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "server_pwm_regs.vh"
module server_pwm_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic busy,
    input wire logic alternate_select_out
);
    logic [15:0] c1_q;
    logic [15:0] c2_q;
    logic tm_q;
    wire wr = psel && penable && pready && pwrite;
    // shadow of the constants and mode bit seen on the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= 16'h0000;
            c2_q <= 16'h0000;
            tm_q <= 1'b0;
        end else if (wr) begin
            if (paddr[11:2] == `IDX_CONST1) c1_q <= pwdata[15:0];
            if (paddr[11:2] == `IDX_CONST2) c2_q <= pwdata[15:0];
            if (paddr[11:2] == `IDX_CONTROL) tm_q <= pwdata[`TOGGLE_MODE_BIT];
        end
    end
    wire [15:0] k = (tm_q && alternate_select_out) ? c2_q : c1_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_done;
        mem_req && !mem_we && mem_ack;
    endsequence
    sequence wr_done;
        mem_req && mem_we && mem_ack;
    endsequence
    a_ready_late: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_sum_right: assert property (rd_done |=> mem_wdata == $past(mem_rdata) + $past(k))
        else $error("wrong sum");
    a_we_follow: assert property (rd_done |=> mem_req && mem_we)
        else $error("no write phase");
    a_cycle_end: assert property (wr_done |=> !mem_req && !busy)
        else $error("cycle did not end");
    a_bit_flip: assert property (wr_done |=> ##1 alternate_select_out != $past(alternate_select_out, 2))
        else $error("toggle bit kept");
    a_addr_hold: assert property (mem_req && $past(mem_req) |-> $stable(mem_addr))
        else $error("address moved");
    a_read_first: assert property ($rose(mem_req) |-> !mem_we)
        else $error("write before read");
    a_busy_req: assert property (busy == mem_req)
        else $error("busy mismatch");
endmodule // server_pwm_sva
bind server_pwm_edge_updater server_pwm_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .busy,
    .alternate_select_out);
`default_nettype wire

// File: bench/event_time_model.sv
`timescale 1ns/1ps
`default_nettype none
module event_time_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] lag,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:255];
    logic [1:0] cnt;
    // one ack pulse per phase after lag cycles; data garbled outside ack
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            cnt <= 2'h0;
            mem_rdata <= 16'h0000;
        end else if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            cnt <= lag;
            mem_rdata <= ~mem_rdata;
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
        end
    end
endmodule // event_time_model
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "server_pwm_regs.vh"
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic service_trigger = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] lag = 2'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, mem_req, mem_we, mem_ack, busy, alternate_select_out, err;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, c1, c2, w;
    logic [7:0] ctls [4] = '{8'h43, 8'h40, 8'h42, 8'h41};
    int error_cnt = 0;
    int n_tests = 0;
    initial forever #5 pclk = ~pclk;
    server_pwm_edge_updater dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .service_trigger, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata, .mem_ack, .busy, .alternate_select_out);
    event_time_model mem_u (.pclk, .presetn, .lag, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata, .mem_ack);
    task give_verdict;
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task tmo;
        error_cnt++;
        $display("[ERR] %0t wait too long", $time);
        give_verdict();
    endtask
    task apb(input logic wr, input logic [9:0] x, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {x, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge pclk);
        if (i == 20) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task fire;
        int i;
        @(posedge pclk);
        service_trigger <= 1'b1;
        @(posedge pclk);
        service_trigger <= 1'b0;
        @(posedge pclk);
        for (i = 0; i < 60; i++) begin
            @(negedge pclk);
            if (busy !== 1'b1) break;
        end
        if (i == 60) tmo();
    endtask
    function logic [15:0] next_word(input logic [15:0] v, input logic tm, input logic t);
        return v + ((tm && t) ? c2 : c1);
    endfunction
    task run(input logic [7:0] ctl, input logic [15:0] ptr);
        logic t;
        apb(1'b1, `IDX_POINTER, ptr);
        apb(1'b1, `IDX_CONST1, c1);
        apb(1'b1, `IDX_CONST2, c2);
        apb(1'b1, `IDX_CONTROL, ctl);
        apb(1'b0, `IDX_CONTROL, 0);
        chk(rd, {24'h00_0000, ctl});
        apb(1'b1, `IDX_SELECT, 1);
        t = ctl[0];
        repeat (5) begin
            lag <= 2'($urandom);
            w = next_word(mem_u.mem[ptr[7:0]], ctl[1], t);
            fire();
            chk(mem_u.mem[ptr[7:0]], w);
            t = ~t;
            apb(1'b0, `IDX_CONTROL, 0);
            chk(rd[0], t);
        end
        apb(1'b1, `IDX_SELECT, 0);
        c1 = 16'($urandom);
        c2 = 16'($urandom);
        mem_u.mem[ptr[7:0]] = mem_u.mem[ptr[7:0]] + c1 + 16'h0010;
        apb(1'b1, `IDX_CONST1, c1);
        apb(1'b1, `IDX_CONST2, c2);
        apb(1'b1, `IDX_SELECT, 1);
        w = next_word(mem_u.mem[ptr[7:0]], ctl[1], t);
        fire();
        chk(mem_u.mem[ptr[7:0]], w);
        t = ~t;
        apb(1'b0, `IDX_STATUS, 0);
        chk(rd, {29'h0000_0000, t, 2'h0});
        apb(1'b1, `IDX_SELECT, 0);
    endtask
    initial begin
        void'($urandom(32'hb2f968cf));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `IDX_CONTROL, 0);
        chk(rd, 0);
        apb(1'b1, `IDX_STATUS, 32'h0000_0007);
        apb(1'b0, `IDX_STATUS, 0);
        chk(rd, 0);
        apb(1'b0, 10'h006, 0);
        chk(err, 1);
        foreach (ctls[k]) begin
            c1 = 16'($urandom);
            c2 = 16'($urandom);
            mem_u.mem[8'h82] = 16'($urandom);
            mem_u.mem[8'h86] = 16'hffff;
            run(ctls[k], k[0] ? 16'h1f86 : 16'h1f82);
        end
        w = mem_u.mem[8'h86];
        fire();
        chk(mem_u.mem[8'h86], w);
        apb(1'b1, `IDX_SELECT, 1);
        apb(1'b1, `IDX_CONTROL, 0);
        fire();
        chk(mem_u.mem[8'h86], w);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
